/* rtl/cfgp_regs.vh */
`ifndef CFGP_REGS_VH
`define CFGP_REGS_VH

// ****************************************************************
// test port widths and instruction codes
// ****************************************************************
`define CFGP_IR_W 6
`define CFGP_DR_W 8
`define CFGP_IR_BYPASS 6'h3F
`define CFGP_IR_USER 6'h02
`define CFGP_IR_CAPTURE 6'h01

// ****************************************************************
// reset values of the pin side
// ****************************************************************
`define CFGP_DONE_OUT_RST 1'h0
`define CFGP_DONE_OE_RST 1'h1
`define CFGP_TDO_RST 1'h0
`define CFGP_TDO_OE_RST 1'h0
`define CFGP_DR_RST 8'h00

// ****************************************************************
// timing counts in clk cycles and test clock rises
// ****************************************************************
`define CFGP_SYNC_STAGES 2
`define CFGP_TLR_TMS_HIGH 5

`endif

/* rtl/cfgp_tap.v */
`timescale 1ns/1ns
`include "cfgp_regs.vh"

module cfgp_tap (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // test clock rising edge strobe and sampled mode select
  input wire step,
  input wire tms,
  // current controller state and decodes of it
  output reg [3:0] state_reg,
  output wire in_tlr,
  output wire in_capture_ir,
  output wire in_shift_ir,
  output wire in_update_ir,
  output wire in_capture_dr,
  output wire in_shift_dr,
  output wire in_update_dr
);

  // ****************************************************************
  // state codes
  // ****************************************************************
  localparam [3:0] ST_EX2DR = 4'h0;
  localparam [3:0] ST_EX1DR = 4'h1;
  localparam [3:0] ST_SHDR = 4'h2;
  localparam [3:0] ST_PAUSEDR = 4'h3;
  localparam [3:0] ST_SELIR = 4'h4;
  localparam [3:0] ST_UPDR = 4'h5;
  localparam [3:0] ST_CAPDR = 4'h6;
  localparam [3:0] ST_SELDR = 4'h7;
  localparam [3:0] ST_EX2IR = 4'h8;
  localparam [3:0] ST_EX1IR = 4'h9;
  localparam [3:0] ST_SHIR = 4'hA;
  localparam [3:0] ST_PAUSEIR = 4'hB;
  localparam [3:0] ST_RTI = 4'hC;
  localparam [3:0] ST_UPIR = 4'hD;
  localparam [3:0] ST_CAPIR = 4'hE;
  localparam [3:0] ST_TLR = 4'hF;

  reg [3:0] state_next;

  // sixteen state walk; any state reaches reset after five high steps
  always @* begin
    case (state_reg)
      ST_TLR: state_next = tms ? ST_TLR : ST_RTI;
      ST_RTI: state_next = tms ? ST_SELDR : ST_RTI;
      ST_SELDR: state_next = tms ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: state_next = tms ? ST_EX1DR : ST_SHDR;
      ST_SHDR: state_next = tms ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: state_next = tms ? ST_UPDR : ST_PAUSEDR;
      ST_PAUSEDR: state_next = tms ? ST_EX2DR : ST_PAUSEDR;
      ST_EX2DR: state_next = tms ? ST_UPDR : ST_SHDR;
      ST_UPDR: state_next = tms ? ST_SELDR : ST_RTI;
      ST_SELIR: state_next = tms ? ST_TLR : ST_CAPIR;
      ST_CAPIR: state_next = tms ? ST_EX1IR : ST_SHIR;
      ST_SHIR: state_next = tms ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: state_next = tms ? ST_UPIR : ST_PAUSEIR;
      ST_PAUSEIR: state_next = tms ? ST_EX2IR : ST_PAUSEIR;
      ST_EX2IR: state_next = tms ? ST_UPIR : ST_SHIR;
      ST_UPIR: state_next = tms ? ST_SELDR : ST_RTI;
      default: state_next = ST_TLR;
    endcase
  end

  // moves only on a test clock rising edge or on reset_n, never on the configuration reset pin
  always @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ST_TLR;
    end else if (step) begin
      state_reg <= state_next;
    end
  end

  // decodes of the state the next edge acts in
  assign in_tlr = (state_reg == ST_TLR);
  assign in_capture_ir = (state_reg == ST_CAPIR);
  assign in_shift_ir = (state_reg == ST_SHIR);
  assign in_update_ir = (state_reg == ST_UPIR);
  assign in_capture_dr = (state_reg == ST_CAPDR);
  assign in_shift_dr = (state_reg == ST_SHDR);
  assign in_update_dr = (state_reg == ST_UPDR);

endmodule

/* rtl/cfgp_top.v */
`timescale 1ns/1ns
`include "cfgp_regs.vh"

// Summary of operation
// - completion pin shows 1 once configured, 0 while not configured.
// - low on configuration reset input asynchronously asserts chip reset and clears configuration, completion pin and suspend.
// - configuration reset pulse never moves the test port state machine.
// - data in is taken on test clock rise into selected register.
// - data out changes on test clock fall from selected register.
// - data out is driven only while shifting, otherwise released.
// - test port state advances by mode select on each clock rise.
// - undriven mode select or data in reads as high.
// - suspend request input puts the device into suspend mode once configured.
module cfgp_top #(
  parameter IR_W = `CFGP_IR_W,
  parameter DR_W = `CFGP_DR_W
) (
  // clock and synchronous reset
  input wire clk,
  input wire reset_n,
  // configuration reset pin, active low, asynchronous
  input wire prog_n,
  // configuration engine status and completion pin mode
  input wire cfg_complete,
  input wire done_drive_active,
  // completion pin, split into its three signals
  input wire done_in,
  output reg done_out_reg,
  output reg done_oe_reg,
  output reg done_seen_reg,
  // chip wide reset towards the fabric
  output reg chip_rst_reg,
  // test port pins; drv inputs tell whether the far side drives
  input wire tck,
  input wire tms_in,
  input wire tms_drv,
  input wire tdi_in,
  input wire tdi_drv,
  output reg tdo_reg,
  output reg tdo_oe_reg,
  // user test data register, parallel sides
  input wire [DR_W-1:0] user_capture,
  output reg [DR_W-1:0] user_update_reg,
  output wire [3:0] tap_state,
  // suspend pin and mode
  input wire suspend_in,
  output reg suspend_reg
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam SW = 7;
  localparam I_TCK = 0;
  localparam I_TMS = 1;
  localparam I_TMSD = 2;
  localparam I_TDI = 3;
  localparam I_TDID = 4;
  localparam I_DONE = 5;
  localparam I_SUSP = 6;

  reg [SW-1:0] sync1_reg;
  reg [SW-1:0] sync2_reg;
  reg tck_prev_reg;
  wire [SW-1:0] pins;
  wire tck_rise;
  wire tck_fall;
  wire tms_eff;
  wire tdi_eff;

  assign pins = {suspend_in, done_in, tdi_drv, tdi_in, tms_drv, tms_in, tck};

  // two stages for every pin; all pins share the same depth so they align
  always @(posedge clk) begin
    if (!reset_n) begin
      sync1_reg <= {SW{1'b0}};
      sync2_reg <= {SW{1'b0}};
      tck_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      tck_prev_reg <= sync2_reg[I_TCK];
    end
  end

  // edges of the test clock as seen by clk; tck must stay below clk/4
  assign tck_rise = sync2_reg[I_TCK] & ~tck_prev_reg;
  assign tck_fall = ~sync2_reg[I_TCK] & tck_prev_reg;

  // pull-up: a floating input reads as high
  assign tms_eff = sync2_reg[I_TMSD] ? sync2_reg[I_TMS] : 1'b1;
  assign tdi_eff = sync2_reg[I_TDID] ? sync2_reg[I_TDI] : 1'b1;

  // ****************************************************************
  // configuration reset and completion
  // ****************************************************************
  reg prog_s1_reg;
  reg prog_s2_reg;
  reg configured_reg;

  // assert at once, release through two stages so no flop sees a runt
  always @(posedge clk or negedge prog_n) begin
    if (!prog_n) begin
      prog_s1_reg <= 1'b0;
      prog_s2_reg <= 1'b0;
      chip_rst_reg <= 1'b1;
    end else if (!reset_n) begin
      prog_s1_reg <= 1'b0;
      prog_s2_reg <= 1'b0;
      chip_rst_reg <= 1'b1;
    end else begin
      prog_s1_reg <= 1'b1;
      prog_s2_reg <= prog_s1_reg;
      chip_rst_reg <= ~prog_s2_reg;
    end
  end

  // configured state and pin drive; the configuration reset pin clears them without clk
  always @(posedge clk or negedge prog_n) begin
    if (!prog_n) begin
      configured_reg <= 1'b0;
      done_out_reg <= `CFGP_DONE_OUT_RST;
      done_oe_reg <= `CFGP_DONE_OE_RST;
      suspend_reg <= 1'b0;
    end else if (!reset_n) begin
      configured_reg <= 1'b0;
      done_out_reg <= `CFGP_DONE_OUT_RST;
      done_oe_reg <= `CFGP_DONE_OE_RST;
      suspend_reg <= 1'b0;
    end else begin
      if (chip_rst_reg) begin
        configured_reg <= 1'b0;
      end else if (cfg_complete) begin
        configured_reg <= 1'b1;
      end
      // active mode drives the level, open-drain only pulls low
      if (done_drive_active) begin
        done_out_reg <= configured_reg;
        done_oe_reg <= 1'b1;
      end else begin
        done_out_reg <= 1'b0;
        done_oe_reg <= ~configured_reg;
      end
      // suspend honoured only once configured, so power-up level is moot
      suspend_reg <= sync2_reg[I_SUSP] & configured_reg;
    end
  end

  // wire level of the completion pin, fed back for the fabric
  always @(posedge clk) begin
    if (!reset_n) begin
      done_seen_reg <= 1'b0;
    end else begin
      done_seen_reg <= sync2_reg[I_DONE];
    end
  end

  // ****************************************************************
  // test access port controller
  // ****************************************************************
  wire t_tlr;
  wire t_cap_ir;
  wire t_sh_ir;
  wire t_up_ir;
  wire t_cap_dr;
  wire t_sh_dr;
  wire t_up_dr;

  // driven by tck edges and reset_n only; prog_n is not connected here
  cfgp_tap u_tap (
    .clk(clk),
    .reset_n(reset_n),
    .step(tck_rise),
    .tms(tms_eff),
    .state_reg(tap_state),
    .in_tlr(t_tlr),
    .in_capture_ir(t_cap_ir),
    .in_shift_ir(t_sh_ir),
    .in_update_ir(t_up_ir),
    .in_capture_dr(t_cap_dr),
    .in_shift_dr(t_sh_dr),
    .in_update_dr(t_up_dr)
  );

  // ****************************************************************
  // instruction and data registers
  // ****************************************************************
  reg [IR_W-1:0] ir_sh_reg;
  reg [IR_W-1:0] ir_reg;
  reg [DR_W-1:0] dr_sh_reg;
  reg bypass_reg;

  // user register is selected by its own code; others fall to bypass
  function sel_user;
    input [IR_W-1:0] ir;
    begin
      sel_user = (ir == `CFGP_IR_USER);
    end
  endfunction

  // capture, shift and update act in the state left by this rise
  always @(posedge clk) begin
    if (!reset_n) begin
      ir_sh_reg <= {IR_W{1'b0}};
      ir_reg <= `CFGP_IR_BYPASS;
      dr_sh_reg <= `CFGP_DR_RST;
      bypass_reg <= 1'b0;
      user_update_reg <= `CFGP_DR_RST;
    end else if (tck_rise) begin
      if (t_tlr) begin
        ir_reg <= `CFGP_IR_BYPASS;
      end
      if (t_cap_ir) begin
        ir_sh_reg <= `CFGP_IR_CAPTURE;
      end
      if (t_sh_ir) begin
        ir_sh_reg <= {tdi_eff, ir_sh_reg[IR_W-1:1]};
      end
      if (t_up_ir) begin
        ir_reg <= ir_sh_reg;
      end
      if (t_cap_dr) begin
        bypass_reg <= 1'b0;
        if (sel_user(ir_reg)) begin
          dr_sh_reg <= user_capture;
        end
      end
      if (t_sh_dr) begin
        if (sel_user(ir_reg)) begin
          dr_sh_reg <= {tdi_eff, dr_sh_reg[DR_W-1:1]};
        end else begin
          bypass_reg <= tdi_eff;
        end
      end
      if (t_up_dr && sel_user(ir_reg)) begin
        user_update_reg <= dr_sh_reg;
      end
    end
  end

  // ****************************************************************
  // serial output
  // ****************************************************************
  // updated on the fall so the far side samples a settled bit on the rise
  always @(posedge clk) begin
    if (!reset_n) begin
      tdo_reg <= `CFGP_TDO_RST;
      tdo_oe_reg <= `CFGP_TDO_OE_RST;
    end else if (tck_fall) begin
      if (t_sh_ir) begin
        tdo_reg <= ir_sh_reg[0];
      end else if (sel_user(ir_reg)) begin
        tdo_reg <= dr_sh_reg[0];
      end else begin
        tdo_reg <= bypass_reg;
      end
      tdo_oe_reg <= t_sh_ir | t_sh_dr;
    end
  end

endmodule

/* tb/cfgp_tap_host.sv */
`timescale 1ns/1ns
module cfgp_tap_host (
  // bench clock
  input wire clk,
  // test port pins
  output reg tck,
  output reg tms_in,
  output reg tms_drv,
  output reg tdi_in,
  output reg tdi_drv,
  input wire tdo_reg,
  input wire tdo_oe_reg
);
  // ********
  // test controller
  // ********
  reg tdo_got;
  reg oe_got;
  // test clock stands low between frames
  initial begin
    tck = 1'b0;
    tms_in = 1'b1;
    tms_drv = 1'b1;
    tdi_in = 1'b1;
    tdi_drv = 1'b1;
    tdo_got = 1'b0;
    oe_got = 1'b0;
  end
  // one 170 ns period; a released pin toggles so only the pull-up
  // inside the device can make it read high
  task pulse(input t, input i, input td, input id);
    begin
      @(negedge clk);
      tms_drv = td;
      tms_in = td ? t : ~tms_in;
      tdi_drv = id;
      tdi_in = id ? i : ~tdi_in;
      repeat (8) @(negedge clk);
      tdo_got = tdo_reg;
      oe_got = tdo_oe_reg;
      tck = 1'b1;
      repeat (8) @(negedge clk);
      tck = 1'b0;
    end
  endtask
endmodule

/* tb/cfgp_top_asserts.sv */
`timescale 1ns/1ns
module cfgp_top_asserts (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // configuration side
  input wire prog_n,
  input wire cfg_complete,
  input wire done_drive_active,
  input wire done_out_reg,
  input wire done_oe_reg,
  input wire chip_rst_reg,
  // test port
  input wire tck,
  input wire tms_drv,
  input wire tdo_reg,
  input wire tdo_oe_reg,
  input wire [3:0] tap_state,
  // suspend
  input wire suspend_in,
  input wire suspend_reg
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  reg [3:0] und_reg;
  // cycles with tms released; saturates so it never wraps to zero
  always @(posedge clk) begin
    if (!reset_n || tms_drv) begin
      und_reg <= 4'h0;
    end else if (und_reg != 4'hF) begin
      und_reg <= und_reg + 4'h1;
    end
  end
  chk_prog_async: assert property (
    !prog_n |-> chip_rst_reg && done_oe_reg && !done_out_reg)
    else $error("config reset not applied");
  chk_done_set: assert property (
    cfg_complete && !chip_rst_reg ##1 prog_n [*2] |-> (done_drive_active ?
    (done_out_reg && done_oe_reg) : (!done_oe_reg && !done_out_reg)))
    else $error("completion pin wrong");
  chk_tdo_fall: assert property (
    $changed(tdo_reg) || $changed(tdo_oe_reg) |-> !tck && !$past(tck))
    else $error("tdo moved off the falling edge");
  chk_state_rise: assert property (
    $changed(tap_state) |-> tck && $past(tck))
    else $error("state moved off the rising edge");
  chk_oe_shift: assert property (
    tdo_oe_reg |-> tap_state inside {4'h2, 4'hA, 4'h1, 4'h9})
    else $error("tdo driven outside shift");
  chk_prog_no_tap: assert property (
    (!tck) [*6] ##0 $fell(prog_n) |-> $stable(tap_state) [*2])
    else $error("config reset moved the state");
  chk_pullup_tms: assert property (
    $changed(tap_state) && und_reg > 4'h5 |->
    !(tap_state inside {4'hC, 4'h6, 4'h2, 4'h3, 4'hE, 4'hA, 4'hB}))
    else $error("released tms not read high");
  chk_suspend_on: assert property (
    suspend_in [*5] ##0 (prog_n && (done_out_reg || !done_oe_reg))
    |-> suspend_reg)
    else $error("suspend not entered");
endmodule
bind cfgp_top cfgp_top_asserts u_chk (.clk(clk), .reset_n(reset_n),
  .prog_n(prog_n), .cfg_complete(cfg_complete),
  .done_drive_active(done_drive_active), .done_out_reg(done_out_reg),
  .done_oe_reg(done_oe_reg), .chip_rst_reg(chip_rst_reg), .tck(tck),
  .tms_drv(tms_drv), .tdo_reg(tdo_reg), .tdo_oe_reg(tdo_oe_reg),
  .tap_state(tap_state), .suspend_in(suspend_in),
  .suspend_reg(suspend_reg));

/* tb/tb.sv */
`timescale 1ns/1ns
`include "cfgp_regs.vh"
`define CHK(g, e) begin got_q.push_back(8'(g)); exp_q.push_back(8'(e)); end
module tb;
  // ********
  // bench
  // ********
  reg clk, reset_n, prog_n, cfg, mode, susp;
  reg [7:0] cap, d;
  wire tck, tms_in, tms_drv, tdi_in, tdi_drv, done_out, done_oe;
  wire done_seen, chip_rst, tdo, tdo_oe, susp_q;
  wire [7:0] upd;
  wire [3:0] st;
  logic [7:0] got_q[$], exp_q[$];
  integer num_errors = 0, cmp_count = 0, cyc = 0, m;
  // released completion pin is pulled high on the board
  wire done_in = done_oe ? done_out : 1'b1;
  cfgp_top u_dut (.clk(clk), .reset_n(reset_n), .prog_n(prog_n),
    .cfg_complete(cfg), .done_drive_active(mode), .done_in(done_in),
    .done_out_reg(done_out), .done_oe_reg(done_oe),
    .done_seen_reg(done_seen), .chip_rst_reg(chip_rst), .tck(tck),
    .tms_in(tms_in), .tms_drv(tms_drv), .tdi_in(tdi_in),
    .tdi_drv(tdi_drv), .tdo_reg(tdo), .tdo_oe_reg(tdo_oe),
    .user_capture(cap), .user_update_reg(upd), .tap_state(st),
    .suspend_in(susp), .suspend_reg(susp_q));
  cfgp_tap_host u_host (.clk(clk), .tck(tck), .tms_in(tms_in),
    .tms_drv(tms_drv), .tdi_in(tdi_in), .tdi_drv(tdi_drv),
    .tdo_reg(tdo), .tdo_oe_reg(tdo_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // oldest note against each result; a hang counts as a mismatch
  always @(posedge clk) begin
    cyc = cyc + 1;
    while (got_q.size() != 0) begin
      cmp_count = cmp_count + 1;
      if (got_q[0] !== exp_q[0]) begin
        num_errors = num_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got_q[0], exp_q[0]);
      end
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
    end
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  task final_report;
    begin
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  task tstep(input t);
    u_host.pulse(t, 1'b0, 1'b1, 1'b1);
  endtask
  // idle to shift, n bits lsb first, back to idle
  task scan(input ir, input [7:0] din, input integer n,
    input [7:0] dexp, input drv);
    integer i;
    reg [7:0] got;
    begin
      got = 8'h00;
      tstep(1'b1);
      if (ir) tstep(1'b1);
      tstep(1'b0);
      tstep(1'b0);
      for (i = 0; i < n; i = i + 1) begin
        u_host.pulse(i == n - 1, din[i], 1'b1, drv);
        got[i] = u_host.tdo_got;
        `CHK(u_host.oe_got, 1'b1)
      end
      tstep(1'b1);
      `CHK(u_host.oe_got, 1'b0)
      tstep(1'b0);
      `CHK(got, dexp)
      `CHK(st, 4'hC)
    end
  endtask
  initial begin
    void'($urandom(38));
    reset_n = 1'b0;
    prog_n = 1'b1;
    cfg = 1'b0;
    mode = 1'b0;
    susp = 1'b0;
    cap = 8'h00;
    d = 8'h00;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    for (m = 0; m < 2; m = m + 1) begin
      prog_n = 1'b0;
      mode = m[0];
      #1 `CHK(chip_rst, 1'b1)
      `CHK({done_oe, done_out}, 2'h2)
      @(negedge clk) prog_n = 1'b1;
      repeat (4) @(negedge clk);
      cfg = 1'b1;
      @(negedge clk) cfg = 1'b0;
      repeat (5) @(negedge clk);
      `CHK({done_oe, done_out, done_seen}, {m[0], m[0], 1'b1})
      // chip reset must also let go once the pin is back high
      `CHK(chip_rst, 1'b0)
    end
    tstep(1'b0);
    scan(1'b1, `CFGP_IR_USER, 6, `CFGP_IR_CAPTURE, 1'b1);
    cap = 8'($urandom);
    d = 8'($urandom);
    // suspend, then a config reset pulse while the test clock idles
    susp = 1'b1;
    repeat (8) @(negedge clk);
    `CHK(susp_q, 1'b1)
    prog_n = 1'b0;
    susp = 1'b0;
    #1 `CHK(susp_q, 1'b0)
    repeat (3) @(negedge clk);
    prog_n = 1'b1;
    `CHK(st, 4'hC)
    scan(1'b0, d, 8, cap, 1'b1);
    `CHK(upd, d)
    // user register again with data in released: only the pull-up fills it
    scan(1'b0, 8'h00, 8, cap, 1'b0);
    `CHK(upd, 8'hFF)
    // into shift, then five rises with tms released
    tstep(1'b1);
    tstep(1'b0);
    tstep(1'b0);
    repeat (4) u_host.pulse(1'b0, 1'b0, 1'b0, 1'b1);
    `CHK(st, 4'h4)
    u_host.pulse(1'b0, 1'b0, 1'b0, 1'b1);
    `CHK(st, 4'hF)
    tstep(1'b0);
    scan(1'b1, 8'h00, 6, `CFGP_IR_CAPTURE, 1'b0);
    scan(1'b0, d, 8, {d[6:0], 1'b0}, 1'b1);
    repeat (4) @(negedge clk);
    final_report;
  end
endmodule
